// >>> common/instr_exec_defs.svh
// Opcode, field and reset constants for the call / skip / clear execution unit
`ifndef INSTR_EXEC_DEFS_SVH
`define INSTR_EXEC_DEFS_SVH

`define OPC_CALL          3'h4
`define OPC_BIT_TEST      4'h6
`define OPC_CLEAR_FILE    7'h03
`define OPC_CLEAR_W       7'h02
`define OPC_CALL_MSB      13
`define OPC_CALL_LSB      11
`define OPC_BIT_TEST_LSB  10
`define OPC_CLR_LSB     7
`define BIT_SEL_MSB     9
`define BIT_SEL_LSB     7
`define FILE_MSB        6
`define LIT_MSB         10
`define LATCH_HI        4
`define LATCH_LO        3
`define PC_HI           12
`define PC_LO           11
`define PC_RESET        13'h0000
`define QPH_RESET       4'h1
`define QPH_Q1          0
`define QPH_Q2          1
`define QPH_Q3          2
`define QPH_Q4          3
`define STACK_DEPTH     8
`define CLEAR_BYTE      8'h00

`endif

// >>> common/instr_exec_pkg.sv
// Types shared by the execution unit and its testbench
package instr_exec_pkg;

  typedef enum logic [2:0] {
    ST_EXEC     = 3'h1,
    ST_NOP_CALL = 3'h2,
    ST_NOP_SKIP = 3'h4
  } exec_state_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } file_port_t;

endpackage

// >>> hdl/return_stack.sv
// Circular return-address stack with silent overwrite on overflow
`timescale 1ns/10ps
`include "instr_exec_defs.svh"

module return_stack #(
  parameter int DEPTH = `STACK_DEPTH,
  parameter int WIDTH = 13
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // Push side
  input  wire logic             push_in,
  input  wire logic [WIDTH-1:0] push_data_in,
  // Top of stack
  output logic      [WIDTH-1:0] top_out
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] entry_q [DEPTH];
  logic [PW-1:0]    ptr_q;
  logic [PW-1:0]    top_idx;

  // Pointer wraps with no full flag, so a ninth push lands on the oldest slot
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ptr_q <= '0;
    end else if (push_in) begin
      ptr_q <= ptr_q + 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          entry_q[gi] <= '0;
        end else if (push_in && ptr_q == PW'(gi)) begin
          entry_q[gi] <= push_data_in;
        end
      end
    end
  endgenerate

  assign top_idx = ptr_q - 1'b1;
  assign top_out = entry_q[top_idx];

  property p_push_wrap;
    @(posedge clk_in) disable iff (!resetn_in)
    push_in |=> (top_out == $past(push_data_in)) && (ptr_q == PW'($past(ptr_q) + 1'b1));
  endproperty
  a_push_wrap: assert property (p_push_wrap) else $error("stack push lost or pointer wrong");

endmodule

// >>> hdl/call_skip_clear_instr_exec.sv
// Execution unit for call, bit test skip when clear, and the two clear instructions
`timescale 1ns/10ps
`include "instr_exec_defs.svh"

module call_skip_clear_instr_exec #(
  parameter int PC_W = 13
) (
  // Clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        resetn_in,
  // Instruction fetch
  input  wire logic [13:0]                 instr_in,
  output logic      [PC_W-1:0]             pc_out,
  // Program counter high latch
  input  wire logic [4:0]                  pc_high_latch_in,
  // File register port
  input  wire logic [7:0]                  file_rdata_in,
  output instr_exec_pkg::file_port_t       file_port_out,
  // Core state
  output logic      [7:0]                  w_out,
  output logic                             zero_out,
  output logic      [PC_W-1:0]             stack_top_entry_out,
  output logic      [3:0]                  quarter_out,
  output logic                             nop_cycle_out
);

  logic [3:0]                  q_q;
  instr_exec_pkg::exec_state_t state_q;
  instr_exec_pkg::exec_state_t state_d;
  logic [13:0]                 ir_q;
  logic [7:0]                  data_q;
  logic [PC_W-1:0]             pc_q;
  logic [PC_W-1:0]             pc_d;
  logic [7:0]                  w_q;
  logic                        z_q;
  instr_exec_pkg::file_port_t  fport_q;

  // Decode
  wire       exec_w        = (state_q == instr_exec_pkg::ST_EXEC);
  wire       is_call       = exec_w && ir_q[`OPC_CALL_MSB:`OPC_CALL_LSB] == `OPC_CALL;
  wire       is_bit_test   = exec_w && ir_q[`OPC_CALL_MSB:`OPC_BIT_TEST_LSB] == `OPC_BIT_TEST;
  wire       is_clear_file = exec_w && ir_q[`OPC_CALL_MSB:`OPC_CLR_LSB] == `OPC_CLEAR_FILE;
  wire       is_clear_w    = exec_w && ir_q[`OPC_CALL_MSB:`OPC_CLR_LSB] == `OPC_CLEAR_W;
  wire [2:0] bit_sel       = ir_q[`BIT_SEL_MSB:`BIT_SEL_LSB];
  wire       bit_clear     = ~data_q[bit_sel];
  wire       skip_w        = is_bit_test && bit_clear;
  wire       q4_w       = q_q[`QPH_Q4];
  wire       push_w     = is_call && q4_w;
  wire [PC_W-1:0] pc_inc = pc_q + 1'b1;
  wire [PC_W-1:0] call_target = {pc_high_latch_in[`LATCH_HI:`LATCH_LO], ir_q[`LIT_MSB:0]};

  // Program counter and state at the end of the cycle
  always_comb begin
    pc_d    = pc_q;
    state_d = state_q;
    unique case (state_q)
      instr_exec_pkg::ST_EXEC: begin
        if (is_call) begin
          pc_d    = call_target;
          state_d = instr_exec_pkg::ST_NOP_CALL;
        end else if (skip_w) begin
          pc_d    = pc_inc;
          state_d = instr_exec_pkg::ST_NOP_SKIP;
        end else begin
          pc_d    = pc_inc;
        end
      end
      instr_exec_pkg::ST_NOP_CALL: begin
        state_d = instr_exec_pkg::ST_EXEC;
      end
      instr_exec_pkg::ST_NOP_SKIP: begin
        pc_d    = pc_inc;
        state_d = instr_exec_pkg::ST_EXEC;
      end
      default: begin
        state_d = instr_exec_pkg::ST_EXEC;
      end
    endcase
  end

  // Quarter phase ring
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q_q <= `QPH_RESET;
    end else begin
      q_q <= {q_q[2:0], q_q[3]};
    end
  end

  // Q1 latches the word; a no-operation cycle latches it too but never decodes it
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ir_q <= '0;
    end else if (q_q[`QPH_Q1]) begin
      ir_q <= instr_in;
    end
  end

  // Q2 reads the addressed register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_q <= '0;
    end else if (q_q[`QPH_Q2]) begin
      data_q <= file_rdata_in;
    end
  end

  // Register write strobe stands for exactly the Q4 quarter
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fport_q <= '0;
    end else begin
      fport_q.we    <= is_clear_file && q_q[`QPH_Q3];
      fport_q.addr  <= ir_q[`FILE_MSB:0];
      fport_q.wdata <= `CLEAR_BYTE;
    end
  end

  // End of cycle: program counter, state, working register, zero flag
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc_q    <= `PC_RESET;
      state_q <= instr_exec_pkg::ST_EXEC;
      w_q     <= '0;
      z_q     <= 1'b0;
    end else if (q4_w) begin
      pc_q    <= pc_d;
      state_q <= state_d;
      if (is_clear_w) begin
        w_q <= `CLEAR_BYTE;
      end
      if (is_clear_w || is_clear_file) begin
        z_q <= 1'b1;
      end
    end
  end

  // Push uses the same Q4 edge as the redirect, so the stack sees the old count
  return_stack #(
    .DEPTH (`STACK_DEPTH),
    .WIDTH (PC_W)
  ) u_stack (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .push_in      (push_w),
    .push_data_in (pc_inc),
    .top_out      (stack_top_entry_out)
  );

  assign pc_out        = pc_q;
  assign file_port_out = fport_q;
  assign w_out         = w_q;
  assign zero_out      = z_q;
  assign quarter_out   = q_q;
  assign nop_cycle_out = !exec_w;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_call_high;
    push_w |=> pc_q[`PC_HI:`PC_LO] == $past(pc_high_latch_in[`LATCH_HI:`LATCH_LO]);
  endproperty
  a_call_high: assert property (p_call_high) else $error("call high bits not from latch");

  property p_call_low;
    push_w |=> pc_q[`LIT_MSB:0] == $past(ir_q[`LIT_MSB:0]);
  endproperty
  a_call_low: assert property (p_call_low) else $error("call literal not loaded");

  property p_call_push;
    push_w |=> stack_top_entry_out == $past(pc_q) + 1'b1;
  endproperty
  a_call_push: assert property (p_call_push) else $error("return address wrong");

  property p_call_two;
    push_w |=> (state_q == instr_exec_pkg::ST_NOP_CALL) [*4] ##1 (state_q == instr_exec_pkg::ST_EXEC);
  endproperty
  a_call_two: assert property (p_call_two) else $error("call not two cycles");

  property p_call_first;
    is_call && q_q[`QPH_Q2] |-> ##2 push_w;
  endproperty
  a_call_first: assert property (p_call_first) else $error("call push not in first cycle");

  property p_call_nop;
    state_q == instr_exec_pkg::ST_NOP_CALL |=> $stable(pc_q) && $stable(w_q) && !fport_q.we;
  endproperty
  a_call_nop: assert property (p_call_nop) else $error("activity in call second cycle");

  property p_skip;
    is_bit_test && q4_w |=> (state_q == instr_exec_pkg::ST_NOP_SKIP) == $past(bit_clear);
  endproperty
  a_skip: assert property (p_skip) else $error("skip decision wrong");

  property p_skip_nop;
    state_q == instr_exec_pkg::ST_NOP_SKIP && q4_w |=> pc_q == $past(pc_q) + 1'b1 && $stable(w_q);
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skip cycle wrong");

  property p_clear_file;
    is_clear_file && q_q[`QPH_Q3] |=> fport_q.we && fport_q.wdata == `CLEAR_BYTE &&
      fport_q.addr == ir_q[`FILE_MSB:0] ##1 !fport_q.we && z_q;
  endproperty
  a_clear_file: assert property (p_clear_file) else $error("clear file register failed");

  property p_clear_w;
    is_clear_w && q4_w |=> w_q == `CLEAR_BYTE && z_q && state_q == instr_exec_pkg::ST_EXEC;
  endproperty
  a_clear_w: assert property (p_clear_w) else $error("clear working register failed");

  c_call:       cover property (push_w);
  c_skip:       cover property (state_q == instr_exec_pkg::ST_NOP_SKIP);
  c_clear_file: cover property (fport_q.we);
  c_clear_w:    cover property (is_clear_w && q4_w);

endmodule

// >>> sim/call_skip_clear_instr_exec_tb.sv
// Self-checking bench for the call, skip and clear execution unit
`timescale 1ns/10ps

module call_skip_clear_instr_exec_tb;
  typedef struct packed {
    logic [13:0] instr;
    logic [4:0]  latch;
    logic [7:0]  rdata;
    logic [12:0] pc;
    logic [12:0] top;
    logic        nop;
    logic        we;
  } row_t;

  logic                       clk_in;
  logic                       resetn_in;
  logic [13:0]                instr_in;
  logic [4:0]                 pc_high_latch_in;
  logic [7:0]                 file_rdata_in;
  logic [12:0]                pc_out;
  logic [12:0]                stack_top_entry_out;
  logic [7:0]                 w_out;
  logic                       zero_out;
  logic [3:0]                 quarter_out;
  logic                       nop_cycle_out;
  instr_exec_pkg::file_port_t file_port_out;
  instr_exec_pkg::file_port_t fp;
  logic                       nop;
  logic [12:0]                pc_q;
  logic [12:0]                top_q;
  logic [12:0]                a;
  int                         errors;
  int                         checked;
  int                         cycles;
  row_t                       rows [9];

  call_skip_clear_instr_exec uut (
    .clk_in              (clk_in),
    .resetn_in           (resetn_in),
    .instr_in            (instr_in),
    .pc_out              (pc_out),
    .pc_high_latch_in    (pc_high_latch_in),
    .file_rdata_in       (file_rdata_in),
    .file_port_out       (file_port_out),
    .w_out               (w_out),
    .zero_out            (zero_out),
    .stack_top_entry_out (stack_top_entry_out),
    .quarter_out         (quarter_out),
    .nop_cycle_out       (nop_cycle_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // The whole run needs about 155 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Entered in the Q4 quarter: loads a word at the Q4 edge, so results taken
  // just after that edge belong to the word before
  task automatic run_cyc(input logic [13:0] i, input logic [4:0] l, input logic [7:0] d);
    @(posedge clk_in);
    instr_in         <= i;
    pc_high_latch_in <= l;
    file_rdata_in    <= d;
    @(negedge clk_in);
    pc_q  = pc_out;
    top_q = stack_top_entry_out;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    fp  = file_port_out;
    nop = nop_cycle_out;
  endtask

  task automatic chk_row(input row_t r);
    chk("pc", 16'(r.pc), 16'(pc_q));
    chk("top", 16'(r.top), 16'(top_q));
    chk("w", 16'h0000, 16'(w_out));
  endtask

  task automatic chk_reset();
    chk("pc", 16'h0000, 16'(pc_out));
    chk("top", 16'h0000, 16'(stack_top_entry_out));
    chk("quarter", 16'h0001, 16'(quarter_out));
    chk("nop", 16'h0000, 16'(nop_cycle_out));
    chk("z", 16'h0000, 16'(zero_out));
    chk("fport", 16'h0000, file_port_out);
  endtask

  task automatic align();
    do @(negedge clk_in); while (quarter_out !== 4'h8);
  endtask

  initial begin
    rows = '{
      '{14'h015a, 5'h00, 8'h00, 13'h0002, 13'h0000, 1'b0, 1'b0},
      '{14'h01a5, 5'h00, 8'h00, 13'h0003, 13'h0000, 1'b0, 1'b1},
      '{14'h198c, 5'h00, 8'hf7, 13'h0005, 13'h0000, 1'b1, 1'b0},
      '{14'h1b8c, 5'h00, 8'h80, 13'h0006, 13'h0000, 1'b0, 1'b0},
      '{14'h180c, 5'h00, 8'hfe, 13'h0008, 13'h0000, 1'b1, 1'b0},
      '{14'h27ff, 5'h18, 8'h00, 13'h1fff, 13'h0009, 1'b1, 1'b0},
      '{14'h0000, 5'h00, 8'h00, 13'h0000, 13'h0009, 1'b0, 1'b0},
      '{14'h2123, 5'h07, 8'h00, 13'h0123, 13'h0001, 1'b1, 1'b0},
      '{14'h1a8c, 5'h00, 8'h20, 13'h0124, 13'h0001, 1'b0, 1'b0}
    };
    resetn_in        = 1'b0;
    instr_in         = 14'h0000;
    pc_high_latch_in = 5'h00;
    file_rdata_in    = 8'h00;
    repeat (10) @(posedge clk_in);
    chk_reset();
    resetn_in <= 1'b1;
    align();
    foreach (rows[k]) begin
      run_cyc(rows[k].instr, rows[k].latch, rows[k].rdata);
      if (k > 0) chk_row(rows[k-1]);
      if (k == 1) chk("z", 16'h0001, 16'(zero_out));
      chk("nop", 16'h0000, 16'(nop));
      chk("we", 16'(rows[k].we), 16'(fp.we));
      if (rows[k].we) chk("fport", {1'b1, rows[k].instr[6:0], 8'h00}, fp);
      if (rows[k].nop) begin
        // A stray register clear in the dead cycle must not reach the port
        run_cyc(14'h01ff, 5'h00, 8'h00);
        chk("nop", 16'h0001, 16'(nop));
        chk("we", 16'h0000, 16'(fp.we));
      end
    end
    run_cyc(14'h0000, 5'h00, 8'h00);
    chk_row(rows[8]);
    // Nine nested calls: one more than the stack holds
    a = 13'h0125;
    for (int i = 0; i < 9; i++) begin
      run_cyc({3'h4, 11'(i * 3)}, 5'h00, 8'h00);
      run_cyc(14'h0000, 5'h00, 8'h00);
      chk("pc", 16'(i * 3), 16'(pc_q));
      chk("top", 16'(a + 13'h0001), 16'(top_q));
      a = 13'(i * 3);
    end
    @(posedge clk_in);
    resetn_in <= 1'b0;
    instr_in  <= 14'h0000;
    @(negedge clk_in);
    chk_reset();
    @(posedge clk_in);
    resetn_in <= 1'b1;
    align();
    run_cyc(14'h01ff, 5'h00, 8'h5a);
    chk("z", 16'h0000, 16'(zero_out));
    chk("fport", 16'hff00, fp);
    run_cyc(14'h0000, 5'h00, 8'h00);
    chk("z", 16'h0001, 16'(zero_out));
    chk("pc", 16'h0002, 16'(pc_q));
    print_verdict();
  end
endmodule
